// [emfc_map.svh]
// Register offsets, field positions, reset values and timing counts of the marker and freeze capture block
`ifndef EMFC_MAP_SVH
`define EMFC_MAP_SVH

`define EMFC_OFF_REF_MARK_POS 8'h00
`define EMFC_OFF_REF_MARK_TURNS 8'h01
`define EMFC_OFF_FBK_MARK_TP 8'h02
`define EMFC_OFF_REF_MARK_TP 8'h03
`define EMFC_OFF_KEYPAD 8'h04
`define EMFC_OFF_EVT_TRIG 8'h05
`define EMFC_OFF_REF_MARK_FLAG 8'h06
`define EMFC_OFF_FBK_MARK_FLAG 8'h07
`define EMFC_OFF_REF_SRC 8'h08
`define EMFC_OFF_FBK_SRC 8'h09
`define EMFC_OFF_REF_MARK_EN 8'h0a
`define EMFC_OFF_FBK_MARK_EN 8'h0b
`define EMFC_OFF_REF_FRZ_EN 8'h0c
`define EMFC_OFF_FBK_FRZ_EN 8'h0d
`define EMFC_OFF_ERR_ID 8'h0e
`define EMFC_OFF_REF_FRZ_FLAG 8'h0f
`define EMFC_OFF_FBK_FRZ_FLAG 8'h10
`define EMFC_OFF_REF_FRZ_TP 8'h11
`define EMFC_OFF_FBK_FRZ_TP 8'h12
`define EMFC_OFF_AUTO_FRZ2 8'h13
`define EMFC_OFF_IRQ_STAT 8'h14
`define EMFC_OFF_IRQ_MASK 8'h15

`define EMFC_KEY_AUX 0
`define EMFC_KEY_RUN 1
`define EMFC_KEY_STOP 2

`define EMFC_IRQ_REF_MARK 0
`define EMFC_IRQ_FBK_MARK 1
`define EMFC_IRQ_REF_FRZ 2
`define EMFC_IRQ_FBK_FRZ 3
`define EMFC_IRQ_ERR 4
`define EMFC_IRQ_W 5

`define EMFC_SRC_UNCONF 8'h05
`define EMFC_EVT_NONE 16'h0000
`define EMFC_EVT_LAST 16'h0004

`define EMFC_CLK_HZ 50000000
`define EMFC_KEY_PERIOD_MS 40
`define EMFC_KEY_CYCLES ((`EMFC_CLK_HZ / 1000) * `EMFC_KEY_PERIOD_MS)

`endif

// [emfc_pkg.sv]
// Types shared by the marker and freeze capture block
package emfc_pkg;

  typedef enum logic [1:0] {
    EMFC_IF_NONE,
    EMFC_IF_PRIMARY,
    EMFC_IF_SECONDARY
  } emfc_if_e;

  // Decoded encoder source: which unit (0 drive, 1..4 slots) and which interface
  typedef struct packed {
    emfc_if_e kind;
    logic [2:0] unit;
  } emfc_src_s;

  // Live encoder sample from one unit
  typedef struct packed {
    logic [15:0] turns;
    logic [31:0] position;
  } emfc_enc_s;

endpackage

// [emfc_capture.sv]
// Encoder marker and freeze capture block with register port and interrupt
// How it works
// - Latch reference position on marker activation
// - Latch reference 16-bit turns on marker
// - Combined word: turns high, position low
// - Keypad bits aux/run/stop, 40 ms refresh
// - Trigger write fires event task immediately
// - Marker sets flag when its enable set
// - Software writes of one ignored
// - Decode 8-bit encoder source selector
// - Primary uses freeze 1, secondary freeze 2
// - Primary source sets freeze 1 source
// - Secondary source sets freeze 2 source
// - Marker flag enables act immediately
// - Freeze enables gate freeze flag setting
// - Load error identifier on module trip
// - Error codes zero through four
// - Freeze flag zero arms, set after capture
`timescale 1ns/100ps
`include "emfc_map.svh"

module emfc_capture (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Encoder positions, marker and freeze inputs per unit (0 drive, 1..4 slots)
  input wire emfc_pkg::emfc_enc_s enc_primary [5],
  input wire emfc_pkg::emfc_enc_s enc_secondary [5],
  input wire logic [4:0] marker_primary,
  input wire logic [4:0] marker_secondary,
  input wire logic [4:0] first_freeze_input,
  input wire logic [4:0] second_freeze_input,
  // Keypad and runtime error
  input wire logic [2:0] keypad_keys,
  input wire logic module_trip,
  input wire logic [31:0] trip_error_id,
  // Freeze source steering towards each unit
  output logic [4:0] first_freeze_src_primary,
  output logic [4:0] second_freeze_src_secondary,
  // Event tasks: base, one, two, three
  output logic [3:0] event_task_start,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Source decode

  function automatic emfc_pkg::emfc_src_s decode_src(input logic [7:0] sel);
    emfc_pkg::emfc_src_s s;
    s.kind = emfc_pkg::EMFC_IF_NONE;
    s.unit = 3'h0;
    case (sel)
      8'h00, 8'h01, 8'h02, 8'h03: begin
        s.kind = emfc_pkg::EMFC_IF_PRIMARY;
        s.unit = sel[2:0];
      end
      8'h06, 8'h07, 8'h08, 8'h09: begin
        s.kind = emfc_pkg::EMFC_IF_SECONDARY;
        s.unit = 3'(sel - 8'h06);
      end
      8'h0a: begin
        s.kind = emfc_pkg::EMFC_IF_PRIMARY;
        s.unit = 3'h4;
      end
      8'h0b: begin
        s.kind = emfc_pkg::EMFC_IF_SECONDARY;
        s.unit = 3'h4;
      end
      // Values 4, 5 and anything above 11 steer nothing
      default: begin
        s.kind = emfc_pkg::EMFC_IF_NONE;
        s.unit = 3'h0;
      end
    endcase
    return s;
  endfunction

  // Selected live sample, marker and freeze edge for one source
  function automatic emfc_pkg::emfc_enc_s pick_enc(input emfc_pkg::emfc_src_s s,
      input emfc_pkg::emfc_enc_s p [5], input emfc_pkg::emfc_enc_s q [5]);
    if (s.kind == emfc_pkg::EMFC_IF_SECONDARY)
      return q[s.unit];
    return p[s.unit];
  endfunction

  function automatic logic pick_bit(input emfc_pkg::emfc_src_s s, input logic [4:0] p, input logic [4:0] q);
    case (s.kind)
      emfc_pkg::EMFC_IF_PRIMARY: return p[s.unit];
      emfc_pkg::EMFC_IF_SECONDARY: return q[s.unit];
      default: return 1'b0;
    endcase
  endfunction

  // Write strobe aimed at one register
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] off);
    return wr && (addr == off);
  endfunction

  // Value a one-bit register holds after this edge, so that a write acts at once
  function automatic logic next_bit(input logic hit, input logic wbit, input logic cur);
    return hit ? wbit : cur;
  endfunction

  // Combined word: turns in the upper half, low half of the position below
  function automatic logic [31:0] pack_tp(input emfc_pkg::emfc_enc_s e);
    return {e.turns, e.position[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] ref_src_q;
  logic [7:0] fbk_src_q;
  logic ref_mark_en_q;
  logic fbk_mark_en_q;
  logic ref_frz_en_q;
  logic fbk_frz_en_q;
  logic auto_frz2_q;
  logic [`EMFC_IRQ_W-1:0] irq_mask_q;
  logic [15:0] evt_trig_q;

  // Sources start unconfigured, so nothing is steered until software picks one
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ref_src_q <= `EMFC_SRC_UNCONF;
      fbk_src_q <= `EMFC_SRC_UNCONF;
      ref_mark_en_q <= 1'b0;
      fbk_mark_en_q <= 1'b0;
      ref_frz_en_q <= 1'b0;
      fbk_frz_en_q <= 1'b0;
      auto_frz2_q <= 1'b1;
      irq_mask_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `EMFC_OFF_REF_SRC: ref_src_q <= reg_wdata[7:0];
        `EMFC_OFF_FBK_SRC: fbk_src_q <= reg_wdata[7:0];
        `EMFC_OFF_REF_MARK_EN: ref_mark_en_q <= reg_wdata[0];
        `EMFC_OFF_FBK_MARK_EN: fbk_mark_en_q <= reg_wdata[0];
        `EMFC_OFF_REF_FRZ_EN: ref_frz_en_q <= reg_wdata[0];
        `EMFC_OFF_FBK_FRZ_EN: fbk_frz_en_q <= reg_wdata[0];
        `EMFC_OFF_AUTO_FRZ2: auto_frz2_q <= reg_wdata[0];
        `EMFC_OFF_IRQ_MASK: irq_mask_q <= reg_wdata[`EMFC_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  emfc_pkg::emfc_src_s ref_src;
  emfc_pkg::emfc_src_s fbk_src;
  assign ref_src = decode_src(ref_src_q);
  assign fbk_src = decode_src(fbk_src_q);

  ////////////////////////////////////////////////////////////////////////////
  // Freeze source steering

  // Steering bits are sticky: a unit stays steered after its source changes
  // Without auto steering nothing sets the second freeze source, and software has no register for it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      first_freeze_src_primary <= 5'h00;
      second_freeze_src_secondary <= 5'h00;
    end else begin
      if (ref_src.kind == emfc_pkg::EMFC_IF_PRIMARY)
        first_freeze_src_primary[ref_src.unit] <= 1'b1;
      if (fbk_src.kind == emfc_pkg::EMFC_IF_PRIMARY)
        first_freeze_src_primary[fbk_src.unit] <= 1'b1;
      if (auto_frz2_q && ref_src.kind == emfc_pkg::EMFC_IF_SECONDARY)
        second_freeze_src_secondary[ref_src.unit] <= 1'b1;
      if (auto_frz2_q && fbk_src.kind == emfc_pkg::EMFC_IF_SECONDARY)
        second_freeze_src_secondary[fbk_src.unit] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection of selected marker and freeze inputs

  // Every raw input keeps its own history, so a change of source cannot fake an edge
  logic [19:0] raw;
  logic [19:0] raw_q;
  logic [19:0] raw_rise;
  logic [3:0] rise;
  assign raw = {second_freeze_input, first_freeze_input, marker_secondary, marker_primary};

  always_ff @(posedge clock) begin
    if (sys_rst)
      raw_q <= 20'h00000;
    else
      raw_q <= raw;
  end
  assign raw_rise = raw & ~raw_q;

  assign rise[0] = pick_bit(ref_src, raw_rise[4:0], raw_rise[9:5]);
  assign rise[1] = pick_bit(fbk_src, raw_rise[4:0], raw_rise[9:5]);
  assign rise[2] = pick_bit(ref_src, raw_rise[14:10], raw_rise[19:15]);
  assign rise[3] = pick_bit(fbk_src, raw_rise[14:10], raw_rise[19:15]);

  emfc_pkg::emfc_enc_s live [2];
  assign live[0] = pick_enc(ref_src, enc_primary, enc_secondary);
  assign live[1] = pick_enc(fbk_src, enc_primary, enc_secondary);

  ////////////////////////////////////////////////////////////////////////////
  // Capture flags and held values: index 0/1 marker ref/fbk, 2/3 freeze ref/fbk

  logic [3:0] flag_q;
  logic [3:0] arm;
  logic [3:0] take;
  emfc_pkg::emfc_enc_s cap_q [4];
  logic [7:0] flag_off [4];
  // Enables gate the capture already at the edge that writes them
  assign arm[0] = next_bit(wr_hit(reg_wr, reg_addr, `EMFC_OFF_REF_MARK_EN), reg_wdata[0], ref_mark_en_q);
  assign arm[1] = next_bit(wr_hit(reg_wr, reg_addr, `EMFC_OFF_FBK_MARK_EN), reg_wdata[0], fbk_mark_en_q);
  assign arm[2] = next_bit(wr_hit(reg_wr, reg_addr, `EMFC_OFF_REF_FRZ_EN), reg_wdata[0], ref_frz_en_q);
  assign arm[3] = next_bit(wr_hit(reg_wr, reg_addr, `EMFC_OFF_FBK_FRZ_EN), reg_wdata[0], fbk_frz_en_q);
  assign flag_off[0] = `EMFC_OFF_REF_MARK_FLAG;
  assign flag_off[1] = `EMFC_OFF_FBK_MARK_FLAG;
  assign flag_off[2] = `EMFC_OFF_REF_FRZ_FLAG;
  assign flag_off[3] = `EMFC_OFF_FBK_FRZ_FLAG;

  // One capture lane per flag; each lane has its own bus clear address, and the lanes share the interrupt line
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cap
      // Capture only while the flag is clear and the enable is set
      assign take[gi] = rise[gi] && arm[gi] && !flag_q[gi];

      always_ff @(posedge clock) begin
        if (sys_rst)
          flag_q[gi] <= 1'b0;
        else if (take[gi])
          flag_q[gi] <= 1'b1;
        else if (wr_hit(reg_wr, reg_addr, flag_off[gi]) && !reg_wdata[0])
          flag_q[gi] <= 1'b0;
        // Writing a one leaves the flag untouched
      end

      // Values stay frozen while the flag is set
      always_ff @(posedge clock) begin
        if (sys_rst)
          cap_q[gi] <= '0;
        else if (take[gi])
          cap_q[gi] <= live[gi % 2];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Keypad sampling every 40 ms

  // Slow sampling keeps contact bounce out of the register
  localparam int KEY_CYCLES = `EMFC_KEY_CYCLES;
  logic [21:0] key_cnt_q;
  logic [2:0] keypad_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      key_cnt_q <= 22'h000000;
      keypad_q <= 3'h0;
    end else if (key_cnt_q == 22'(KEY_CYCLES - 1)) begin
      key_cnt_q <= 22'h000000;
      keypad_q <= keypad_keys;
    end else begin
      key_cnt_q <= key_cnt_q + 22'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event trigger and runtime error

  logic [31:0] err_id_q;

  // The start pulse lasts one cycle; the stored value only reads back
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      evt_trig_q <= `EMFC_EVT_NONE;
      event_task_start <= 4'h0;
    end else begin
      event_task_start <= 4'h0;
      if (wr_hit(reg_wr, reg_addr, `EMFC_OFF_EVT_TRIG)) begin
        evt_trig_q <= reg_wdata[15:0];
        // Values above the last task code start nothing
        if (reg_wdata[15:0] != `EMFC_EVT_NONE && reg_wdata[15:0] <= `EMFC_EVT_LAST)
          event_task_start[2'(reg_wdata[15:0] - 16'h0001)] <= 1'b1;
      end
    end
  end

  // Every trip cycle reloads the code, so the last trip wins
  always_ff @(posedge clock) begin
    if (sys_rst)
      err_id_q <= 32'h00000000;
    else if (module_trip)
      err_id_q <= trip_error_id;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over write-one-to-clear

  logic [`EMFC_IRQ_W-1:0] irq_stat_q;
  logic [`EMFC_IRQ_W-1:0] irq_stat_d;
  logic [`EMFC_IRQ_W-1:0] irq_mask_d;
  logic [`EMFC_IRQ_W-1:0] irq_set;
  logic [`EMFC_IRQ_W-1:0] irq_clr;
  assign irq_set = {module_trip, take};
  assign irq_clr = wr_hit(reg_wr, reg_addr, `EMFC_OFF_IRQ_STAT) ? reg_wdata[`EMFC_IRQ_W-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
  // The line follows the next status and mask, so it never lags a write by a cycle
  assign irq_mask_d = wr_hit(reg_wr, reg_addr, `EMFC_OFF_IRQ_MASK) ? reg_wdata[`EMFC_IRQ_W-1:0] : irq_mask_q;

  always_ff @(posedge clock) begin
    if (sys_rst)
      irq_stat_q <= '0;
    else
      irq_stat_q <= irq_stat_d;
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_d & irq_mask_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  // Cycles without a read return zero, so no stale word looks like an answer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `EMFC_OFF_REF_MARK_POS: reg_rdata <= cap_q[0].position;
        `EMFC_OFF_REF_MARK_TURNS: reg_rdata <= {16'h0000, cap_q[0].turns};
        `EMFC_OFF_FBK_MARK_TP: reg_rdata <= pack_tp(cap_q[1]);
        `EMFC_OFF_REF_MARK_TP: reg_rdata <= pack_tp(cap_q[0]);
        `EMFC_OFF_KEYPAD: reg_rdata <= {29'h00000000, keypad_q};
        `EMFC_OFF_EVT_TRIG: reg_rdata <= {16'h0000, evt_trig_q};
        `EMFC_OFF_REF_MARK_FLAG: reg_rdata <= {31'h00000000, flag_q[0]};
        `EMFC_OFF_FBK_MARK_FLAG: reg_rdata <= {31'h00000000, flag_q[1]};
        `EMFC_OFF_REF_SRC: reg_rdata <= {24'h000000, ref_src_q};
        `EMFC_OFF_FBK_SRC: reg_rdata <= {24'h000000, fbk_src_q};
        `EMFC_OFF_REF_MARK_EN: reg_rdata <= {31'h00000000, ref_mark_en_q};
        `EMFC_OFF_FBK_MARK_EN: reg_rdata <= {31'h00000000, fbk_mark_en_q};
        `EMFC_OFF_REF_FRZ_EN: reg_rdata <= {31'h00000000, ref_frz_en_q};
        `EMFC_OFF_FBK_FRZ_EN: reg_rdata <= {31'h00000000, fbk_frz_en_q};
        `EMFC_OFF_ERR_ID: reg_rdata <= err_id_q;
        `EMFC_OFF_REF_FRZ_FLAG: reg_rdata <= {31'h00000000, flag_q[2]};
        `EMFC_OFF_FBK_FRZ_FLAG: reg_rdata <= {31'h00000000, flag_q[3]};
        `EMFC_OFF_REF_FRZ_TP: reg_rdata <= pack_tp(cap_q[2]);
        `EMFC_OFF_FBK_FRZ_TP: reg_rdata <= pack_tp(cap_q[3]);
        `EMFC_OFF_AUTO_FRZ2: reg_rdata <= {31'h00000000, auto_frz2_q};
        `EMFC_OFF_IRQ_STAT: reg_rdata <= {27'h0000000, irq_stat_q};
        `EMFC_OFF_IRQ_MASK: reg_rdata <= {27'h0000000, irq_mask_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// [emfc_capture_asserts.sv]
// Port checker of the marker and freeze capture block
`timescale 1ns/100ps
module emfc_capture_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Outputs
  input wire logic [4:0] first_freeze_src_primary,
  input wire logic [3:0] event_task_start,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic src_wr = reg_wr && reg_addr inside {8'h08, 8'h09};
  wire logic evt_wr = reg_wr && reg_addr == 8'h05 && reg_wdata[15:0] inside {[16'h1:16'h4]};
  ////////////////////////////////////////
  AST_RDATA_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside a read");
  AST_EVT_PULSE:
    assert property (evt_wr |=> event_task_start == (4'h1 << ($past(reg_wdata[2:0]) - 3'h1))) else $error("bad task");
  AST_EVT_QUIET:
    assert property (!evt_wr |=> event_task_start == 4'h0) else $error("task start without trigger");
  AST_EVT_ONE:
    assert property ($onehot0(event_task_start)) else $error("two tasks at once");
  AST_MASK_OFF:
    assert property (reg_wr && reg_addr == 8'h15 && reg_wdata[4:0] == 5'h0 |=> !irq) else $error("irq while masked");
  AST_FLAG_NARROW:
    assert property (reg_rd && reg_addr inside {8'h06, 8'h07} |=> reg_rdata[31:1] == 31'h0) else $error("flag width");
  AST_SRC_STICKY:
    assert property (($past(first_freeze_src_primary) & ~first_freeze_src_primary) == 5'h0) else $error("steer lost");
  AST_SRC_SET:
    assert property (src_wr && reg_wdata <= 32'h3 |-> ##2 first_freeze_src_primary[$past(reg_wdata[1:0], 2)])
    else $error("primary steer missing");
  AST_SRC_CAUSE:
    assert property ((first_freeze_src_primary & ~$past(first_freeze_src_primary)) != 5'h0 |-> $past(src_wr, 2))
    else $error("steer without source write");
endmodule
bind emfc_capture emfc_capture_asserts chk_u (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .first_freeze_src_primary, .event_task_start, .irq);

// [emfc_enc_model.sv]
// Drive and slot encoder interfaces facing the capture block
`timescale 1ns/100ps
module emfc_enc_model (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Commands: advance positions, pulse requests {freeze 2, freeze 1, marker s, marker p}
  input wire logic advance,
  input wire logic [19:0] req,
  // Encoder interfaces
  output emfc_pkg::emfc_enc_s enc_primary [5],
  output emfc_pkg::emfc_enc_s enc_secondary [5],
  output logic [4:0] marker_primary,
  output logic [4:0] marker_secondary,
  output logic [4:0] first_freeze_input,
  output logic [4:0] second_freeze_input
);
  logic [15:0] cnt_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= 16'h0;
    end else if (advance) begin
      cnt_q <= cnt_q + 16'h1357;
    end
  end
  // Pulses lag the request by one cycle and rest low
  always_ff @(posedge clock) begin
    {second_freeze_input, first_freeze_input, marker_secondary, marker_primary} <= sys_rst ? 20'h0 : req;
  end
  // Positions differ per unit and interface; turns differ per unit on the primary interface only
  always_comb begin
    for (int u = 0; u < 5; u++) begin
      enc_primary[u] = {cnt_q + 16'(u), 8'(8'h80 + u), 8'h5a, cnt_q ^ 16'(u)};
      enc_secondary[u] = {~cnt_q, 8'(8'h40 + u), 8'ha5, cnt_q + 16'(u + 7)};
    end
  end
endmodule

// [emfc_capture_bench.sv]
// Self-checking bench of the marker and freeze capture block
`timescale 1ns/100ps
module emfc_capture_bench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic advance = 1'b0;
  logic module_trip = 1'b0;
  logic [31:0] trip_id = 32'h0;
  logic [2:0] keys = 3'h0;
  logic [19:0] req = 20'h0;
  logic [31:0] reg_rdata;
  logic [4:0] mk_p, mk_s, fz_1, fz_2, ffsp, fssp;
  logic [3:0] evt;
  logic irq;
  emfc_pkg::emfc_enc_s enc_p [5];
  emfc_pkg::emfc_enc_s enc_s [5];
  int err_count = 0;
  int comparisons = 0;
  initial begin
    forever #10 clock = ~clock;
  end
  emfc_enc_model mdl_u (.clock(clock), .sys_rst(sys_rst), .advance(advance), .req(req), .enc_primary(enc_p),
    .enc_secondary(enc_s), .marker_primary(mk_p), .marker_secondary(mk_s), .first_freeze_input(fz_1),
    .second_freeze_input(fz_2));
  emfc_capture dut_u (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_primary(enc_p), .enc_secondary(enc_s),
    .marker_primary(mk_p), .marker_secondary(mk_s), .first_freeze_input(fz_1), .second_freeze_input(fz_2),
    .keypad_keys(keys), .module_trip(module_trip), .trip_error_id(trip_id), .first_freeze_src_primary(ffsp),
    .second_freeze_src_secondary(fssp), .event_task_start(evt), .irq(irq));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic pulse(input logic [19:0] v);
    @(posedge clock);
    req <= v;
    repeat (2) @(posedge clock);
    req <= 20'h0;
    repeat (2) @(posedge clock);
  endtask
  task automatic step();
    @(posedge clock);
    advance <= 1'b1;
    @(posedge clock);
    advance <= 1'b0;
    @(posedge clock);
  endtask
  task automatic do_reset();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_reset_vals();
    keys <= 3'h7;
    rc(8'h08, 32'h5);
    rc(8'h0a, 32'h0);
    rc(8'h13, 32'h1);
    wr(8'h3f, 32'hffffffff);
    rc(8'h3f, 32'h0);
    wr(8'h00, 32'h1234);
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h0);
  endtask
  task automatic t_event();
    for (int v = 0; v < 6; v++) begin
      wr(8'h05, 32'(v));
      #1 chk("task start", (v inside {[1:4]}) ? 32'h1 << (v - 1) : 32'h0, {28'h0, evt});
      rc(8'h05, 32'(v));
    end
  endtask
  task automatic t_marker();
    logic [47:0] r, f;
    wr(8'h08, 32'h0);
    wr(8'h09, 32'h7);
    pulse(20'h1);
    rc(8'h06, 32'h0);
    wr(8'h0a, 32'h1);
    wr(8'h0b, 32'h1);
    wr(8'h15, 32'h3);
    wr(8'h06, 32'h1);
    rc(8'h06, 32'h0);
    step();
    r = enc_p[0];
    f = enc_s[1];
    pulse(20'h41);
    rc(8'h06, 32'h1);
    rc(8'h07, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    step();
    pulse(20'h41);
    rc(8'h00, r[31:0]);
    rc(8'h01, {16'h0, r[47:32]});
    rc(8'h03, {r[47:32], r[15:0]});
    rc(8'h02, {f[47:32], f[15:0]});
    wr(8'h06, 32'h0);
    rc(8'h06, 32'h0);
    pulse(20'h1);
    rc(8'h00, enc_p[0].position);
    wr(8'h14, 32'h3);
    wr(8'h15, 32'h0);
  endtask
  task automatic t_trip();
    wr(8'h15, 32'h10);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      module_trip <= 1'b1;
      trip_id <= 32'(4 - i);
      @(posedge clock);
      module_trip <= 1'b0;
      rc(8'h0e, 32'(4 - i));
    end
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h14, 32'h10);
    #1 chk("irq", 32'h0, {31'h0, irq});
  endtask
  task automatic t_source();
    logic [47:0] r;
    do_reset();
    wr(8'h13, 32'h0);
    wr(8'h08, 32'h6);
    repeat (2) @(posedge clock);
    #1 chk("steer 2", 32'h0, {27'h0, fssp});
    wr(8'h13, 32'h1);
    for (int s = 0; s < 12; s++) begin
      wr(8'h08, 32'(s));
      rc(8'h08, 32'(s));
    end
    chk("steer 1", 32'h1f, {27'h0, ffsp});
    chk("steer 2", 32'h1f, {27'h0, fssp});
    wr(8'h0c, 32'h1);
    pulse(20'h4000);
    rc(8'h0f, 32'h0);
    r = enc_s[4];
    pulse(20'h80000);
    rc(8'h0f, 32'h1);
    rc(8'h11, {r[47:32], r[15:0]});
    wr(8'h09, 32'h4);
    wr(8'h0d, 32'h1);
    pulse(20'hffc00);
    rc(8'h10, 32'h0);
    wr(8'h0d, 32'h0);
    wr(8'h09, 32'h2);
    pulse(20'h1000);
    rc(8'h10, 32'h0);
    wr(8'h0d, 32'h1);
    pulse(20'h1000);
    rc(8'h10, 32'h1);
    wr(8'h10, 32'h0);
    rc(8'h10, 32'h0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    give_verdict();
  end
  initial begin
    do_reset();
    t_reset_vals();
    t_event();
    t_marker();
    t_trip();
    t_source();
    give_verdict();
  end
endmodule
